// ===== pkg/cpu_state_pkg.sv
package cpu_state_pkg;
  // ==========================================================
  // Status word field positions (big-endian bit numbering mapped to LSB=0)
  localparam int SM_POS = 7;
  localparam int IE_POS = 6;
  localparam int C_POS = 0;
  localparam int BSM_POS = 15;
  localparam int BIE_POS = 14;
  localparam int BC_POS = 8;
  localparam logic [31:0] PSW_MASK = 32'h0000_C1C1;
  localparam logic [31:0] PSW_RESET = 32'h0000_0000;
  // ==========================================================
  // Address map boundaries
  localparam logic [31:0] IO_SPACE_BASE = 32'h8000_0000;
  localparam logic [31:0] USER_LIMIT = 32'h00FF_FFFF;
  localparam logic [31:0] DRAM_LIMIT = 32'h001F_FFFF;
  localparam logic [31:0] EXT_BASE = 32'h0020_0000;
  localparam logic [31:0] UIO_BASE = 32'hFF00_0000;
  localparam logic [31:0] UIO_LIMIT = 32'hFF7F_FFFF;
  localparam logic [31:0] SYS_BASE = 32'hFF80_0000;
  localparam logic [31:0] SYS_LIMIT = 32'hFFBF_FFFF;
  localparam logic [31:0] INTIO_BASE = 32'hFFC0_0000;
  // ==========================================================
  // Vector entries
  localparam logic [31:0] VEC_RESET = 32'h00FF_FFF0;
  localparam logic [31:0] VEC_RIE = 32'h0000_0000;
  localparam logic [31:0] VEC_AE = 32'h0000_0010;
  localparam logic [31:0] VEC_SBI = 32'h0000_0020;
  localparam logic [31:0] VEC_WI = 32'h0000_0030;
  localparam logic [31:0] VEC_EI = 32'h0000_0040;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0050;
  localparam logic [31:0] VEC_TOP = 32'h0000_008F;
  localparam int TRAP_SHIFT = 2;
  // ==========================================================
  // Control register selectors
  localparam logic [2:0] CR_PSW = 3'h0;
  localparam logic [2:0] CR_CBR = 3'h1;
  localparam logic [2:0] CR_SPI = 3'h2;
  localparam logic [2:0] CR_SPU = 3'h3;
  localparam logic [2:0] CR_BPC = 3'h6;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    MEM_NONE = 3'h0, MEM_LB = 3'h1, MEM_LUB = 3'h2, MEM_LH = 3'h3,
    MEM_LUH = 3'h4, MEM_LW = 3'h5, MEM_SB = 3'h6, MEM_SH = 3'h7
  } mem_op_t;
  typedef enum logic [2:0] {
    EV_NONE = 3'h0, EV_RESET = 3'h1, EV_SBI = 3'h3, EV_AE = 3'h2,
    EV_RIE = 3'h6, EV_WI = 3'h7, EV_EI = 3'h5, EV_TRAP = 3'h4
  } event_t;
  typedef enum logic [1:0] {
    RUN = 2'b00, SLEEP = 2'b01, STANDBY = 2'b11, SLAVE_WAIT = 2'b10
  } pwr_t;
  typedef enum logic [2:0] {
    AREA_DRAM = 3'h0, AREA_EXT = 3'h1, AREA_UNUSED = 3'h2, AREA_UIO = 3'h3,
    AREA_SYS = 3'h4, AREA_INTIO = 3'h5, AREA_IO_UNUSED = 3'h6
  } area_t;
  typedef struct packed {
    logic space_id;
    logic cacheable;
    area_t area;
    logic usable;
  } addr_info_t;
  typedef struct packed {
    logic we;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } store_t;
endpackage : cpu_state_pkg

// ===== hw/addr_decoder.sv
`timescale 1ns/100ps
// Combinational logical address classifier
module addr_decoder
  import cpu_state_pkg::*;
(
  input wire logic [31:0] addr,
  output addr_info_t info
);
  // ==========================================================
  // Decode
  always_comb begin
    info.space_id = (addr >= IO_SPACE_BASE);
    info.cacheable = ~info.space_id;  // I/O never cached
    info.usable = 1'b1;
    if (addr <= DRAM_LIMIT) begin
      info.area = AREA_DRAM;
    end else if (addr >= EXT_BASE && addr <= USER_LIMIT) begin
      info.area = AREA_EXT;
    end else if (!info.space_id) begin
      info.area = AREA_UNUSED;  // Beyond usable 16 MB
      info.usable = 1'b0;
    end else if (addr >= UIO_BASE && addr <= UIO_LIMIT) begin
      info.area = AREA_UIO;
    end else if (addr >= SYS_BASE && addr <= SYS_LIMIT) begin
      info.area = AREA_SYS;  // Debug tools only
      info.usable = 1'b0;
    end else if (addr >= INTIO_BASE) begin
      info.area = AREA_INTIO;
    end else begin
      info.area = AREA_IO_UNUSED;
      info.usable = 1'b0;
    end
  end
endmodule : addr_decoder

// ===== hw/cpu_status_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - Event saves mode, enable, condition into backup
// - Condition copy mirrors C; writes ignored
// - R15 selects interrupt or user stack
// - Backup PC captures current/next; LSB zero
// - Return loads PC with low bits cleared
// - 64-bit accumulator, half writes, three reads
// - Program counter LSB always zero
// - Signed loads sign-extend, unsigned zero-extend
// - Stores write low half, low byte; no word store
// - Misaligned half/word access raises address exception
// - Low half of space is user space
// - Upper half is I/O, never cached
// - Low 2 MB is DRAM with vectors
// - External area; reset vector at top
// - User I/O area drives external bus
// - System area reserved; internal I/O above
// - Reserved opcode raises exception
// - Reset is always accepted, highest priority
// - Wakeup only accepted in standby
// - System break ends sleep, starts slave
// - External interrupt maskable; ends sleep, starts slave
// - Trap operand selects one of 16 vectors
// - System break ignores interrupt enable
module cpu_status_unit
  import cpu_state_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // Control register move port
  input wire logic cr_we,
  input wire logic [2:0] cr_sel,
  input wire logic [31:0] cr_wdata,
  output logic [31:0] cr_rdata,
  // Stack pointer view as R15
  input wire logic r15_we,
  input wire logic [31:0] r15_wdata,
  output logic [31:0] r15_rdata,
  // Condition bit result from the ALU
  input wire logic cond_we,
  input wire logic cond_in,
  // Program counter flow
  input wire logic pc_load,
  input wire logic [31:0] pc_target,
  input wire logic retire,
  input wire logic [31:0] next_pc,
  input wire logic save_next,
  input wire logic return_from_event_instr,
  output logic [31:0] pc,
  // Accumulator port
  input wire logic write_acc_high_instr,
  input wire logic write_acc_low_instr,
  input wire logic [31:0] acc_wdata,
  input wire logic [1:0] acc_rsel,
  output logic [31:0] acc_rdata,
  // Memory access formatting
  input wire logic mem_valid,
  input wire mem_op_t mem_op,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic [31:0] store_src,
  output logic [31:0] load_result,
  output store_t store_out,
  output addr_info_t addr_info,
  // Event sources
  input wire logic reserved_opcode,
  input wire logic trap_instr,
  input wire logic [3:0] trap_operand,
  input wire logic system_break,
  input wire logic ext_interrupt,
  input wire logic wakeup_input,
  input wire logic sleep_req,
  input wire logic standby_req,
  input wire logic slave_mode,
  output logic event_taken,
  output event_t event_kind,
  output logic alignment_exception,
  output logic [1:0] power_state
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] processor_status_word;  // Status word with backup field
    logic [31:0] spi;  // Interrupt stack
    logic [31:0] user_stack_pointer;  // User stack
    logic [31:0] backup_program_counter;  // Backup PC
    logic [31:0] pc;  // Program counter
    logic [63:0] acc;  // Accumulator
    pwr_t pwr;  // Power / start mode
    logic [31:0] cr_rdata;
    logic [31:0] r15_rdata;
    logic [31:0] acc_rdata;
    logic [31:0] load_result;
    store_t store_out;
    addr_info_t addr_info;
    logic event_taken;
    event_t event_kind;
    logic alignment_exception;
  } state_t;
  state_t s_q;
  state_t s_d;
  addr_info_t dec_info;  // Address class of the pending access
  logic misaligned;  // Half or word off its boundary
  logic [31:0] cond_copy;  // Read view of the condition copy
  logic ei_ok;  // Unmasked external interrupt
  // ==========================================================
  // Address decoder
  addr_decoder u_dec (
    .addr(mem_addr),
    .info(dec_info)
  );
  // ==========================================================
  // Alignment check for loads and stores
  always_comb begin
    unique case (mem_op)
      MEM_LH, MEM_LUH, MEM_SH: misaligned = mem_addr[0];
      MEM_LW: misaligned = |mem_addr[1:0];
      default: misaligned = 1'b0;  // Bytes and none; never misaligned
    endcase
  end
  // Follows this cycle's condition update so the copy never lags the status word
  assign cond_copy = {31'h0000_0000, s_d.processor_status_word[C_POS]};
  assign ei_ok = ext_interrupt & s_q.processor_status_word[IE_POS];
  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [31:0] vec;
    logic [31:0] ld;
    logic mis;
    vec = VEC_RIE;
    ld = 32'h0000_0000;
    mis = 1'b0;
    s_d = s_q;
    s_d.event_taken = 1'b0;
    s_d.event_kind = EV_NONE;
    mis = mem_valid & misaligned;
    s_d.alignment_exception = mis;
    // Load extension
    unique case (mem_op)
      MEM_LB: ld = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
      MEM_LUB: ld = {24'h00_0000, mem_rdata[7:0]};
      MEM_LH: ld = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
      MEM_LUH: ld = {16'h0000, mem_rdata[15:0]};
      default: ld = mem_rdata;
    endcase
    s_d.load_result = ld;
    // Store width: only low bits leave the register
    s_d.store_out.we = mem_valid & ~mis & (mem_op == MEM_SB || mem_op == MEM_SH);
    unique case (mem_op)
      MEM_SB: begin
        s_d.store_out.byte_en = 4'h1;
        s_d.store_out.wdata = {24'h00_0000, store_src[7:0]};
      end
      MEM_SH: begin
        s_d.store_out.byte_en = 4'h3;
        s_d.store_out.wdata = {16'h0000, store_src[15:0]};
      end
      default: begin
        s_d.store_out.byte_en = 4'hF;  // All lanes enabled; we stays low
        s_d.store_out.wdata = store_src;
      end
    endcase
    s_d.addr_info = dec_info;
    // Condition bit update
    if (cond_we) begin
      s_d.processor_status_word[C_POS] = cond_in;
    end
    // Control register writes; condition copy silently drops them
    if (cr_we) begin
      unique case (cr_sel)
        CR_PSW: s_d.processor_status_word = cr_wdata & PSW_MASK;
        CR_SPI: s_d.spi = cr_wdata;
        CR_SPU: s_d.user_stack_pointer = cr_wdata;
        CR_BPC: s_d.backup_program_counter = {cr_wdata[31:1], 1'b0};  // LSB fixed at zero
        default: s_d.processor_status_word = s_d.processor_status_word;
      endcase
    end
    // R15 alias picks the stack by mode bit
    if (r15_we) begin
      if (s_q.processor_status_word[SM_POS]) s_d.user_stack_pointer = r15_wdata;
      else s_d.spi = r15_wdata;
    end
    // Accumulator halves
    if (write_acc_high_instr) s_d.acc[63:32] = acc_wdata;
    if (write_acc_low_instr) s_d.acc[31:0] = acc_wdata;
    // Program counter flow; LSB is held at zero
    if (return_from_event_instr) begin
      s_d.pc = {s_q.backup_program_counter[31:2], 2'b00};
    end else if (pc_load) begin
      s_d.pc = {pc_target[31:1], 1'b0};
    end else if (retire) begin
      s_d.pc = {next_pc[31:1], 1'b0};
    end
    // Power modes: sleep and slave wait leave on break or interrupt
    unique case (s_q.pwr)
      RUN: begin
        if (standby_req) s_d.pwr = STANDBY;
        else if (sleep_req) s_d.pwr = SLEEP;
      end
      SLEEP, SLAVE_WAIT: begin
        if (system_break || ext_interrupt) s_d.pwr = RUN;
      end
      STANDBY: begin
        if (wakeup_input) s_d.pwr = RUN;
      end
    endcase
    // Event priority, highest first
    if (s_q.pwr == STANDBY) begin
      if (wakeup_input) begin
        s_d.event_kind = EV_WI;  // Only standby exit
        vec = VEC_WI;
      end
    end else if (system_break) begin
      s_d.event_kind = EV_SBI;  // Not masked by enable
      vec = VEC_SBI;
    end else if (s_q.pwr == RUN && mis) begin
      s_d.event_kind = EV_AE;
      vec = VEC_AE;
    end else if (s_q.pwr == RUN && reserved_opcode) begin
      s_d.event_kind = EV_RIE;
      vec = VEC_RIE;
    end else if (ei_ok) begin
      s_d.event_kind = EV_EI;
      vec = VEC_EI;
    end else if (s_q.pwr == RUN && trap_instr) begin
      s_d.event_kind = EV_TRAP;
      vec = VEC_TRAP + {26'h000_0000, trap_operand, 2'b00};
    end
    if (s_d.event_kind != EV_NONE) begin
      s_d.event_taken = 1'b1;
      // Save mode, enable, condition into backup field
      s_d.processor_status_word[BSM_POS] = s_q.processor_status_word[SM_POS];
      s_d.processor_status_word[BIE_POS] = s_q.processor_status_word[IE_POS];
      s_d.processor_status_word[BC_POS] = s_q.processor_status_word[C_POS];
      s_d.processor_status_word[SM_POS] = 1'b0;
      s_d.processor_status_word[IE_POS] = 1'b0;
      // Faults resume at the failing instruction, others after it when save_next is set
      if (save_next && s_d.event_kind != EV_AE && s_d.event_kind != EV_RIE) begin
        s_d.backup_program_counter = {next_pc[31:1], 1'b0};
      end else begin
        s_d.backup_program_counter = {s_q.pc[31:1], 1'b0};
      end
      s_d.pc = vec;
      if (s_d.event_kind == EV_WI || s_d.event_kind == EV_SBI) s_d.pwr = RUN;
    end
    // Registered read ports
    unique case (cr_sel)
      CR_PSW: s_d.cr_rdata = s_d.processor_status_word;
      CR_CBR: s_d.cr_rdata = cond_copy;
      CR_SPI: s_d.cr_rdata = s_d.spi;
      CR_SPU: s_d.cr_rdata = s_d.user_stack_pointer;
      CR_BPC: s_d.cr_rdata = s_d.backup_program_counter;
      default: s_d.cr_rdata = 32'h0000_0000;
    endcase
    s_d.r15_rdata = s_d.processor_status_word[SM_POS] ? s_d.user_stack_pointer : s_d.spi;
    unique case (acc_rsel)
      2'b00: s_d.acc_rdata = s_d.acc[63:32];
      2'b01: s_d.acc_rdata = s_d.acc[31:0];
      2'b10: s_d.acc_rdata = s_d.acc[47:16];  // Middle view
      default: s_d.acc_rdata = 32'h0000_0000;
    endcase
  end
  // ==========================================================
  // Registers; reset vectors fetch and wins over every source
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.processor_status_word <= PSW_RESET;
      s_q.pc <= VEC_RESET;
      s_q.event_taken <= 1'b1;
      s_q.event_kind <= EV_RESET;
      s_q.pwr <= RUN;
    end else begin
      s_q <= s_d;
      if (s_q.event_kind == EV_RESET && slave_mode) s_q.pwr <= SLAVE_WAIT;
    end
  end
  // ==========================================================
  // Outputs
  assign cr_rdata = s_q.cr_rdata;
  assign r15_rdata = s_q.r15_rdata;
  assign pc = s_q.pc;
  assign acc_rdata = s_q.acc_rdata;
  assign load_result = s_q.load_result;
  assign store_out = s_q.store_out;
  assign addr_info = s_q.addr_info;
  assign event_taken = s_q.event_taken;
  assign event_kind = s_q.event_kind;
  assign alignment_exception = s_q.alignment_exception;
  assign power_state = s_q.pwr;
endmodule : cpu_status_unit

// ===== testbench/irq_source.sv
`timescale 1ns/100ps
// ==========================================
// Outside event pins: break, interrupt, wakeup
module irq_source (
  input wire logic ref_clk,
  output logic system_break,
  output logic ext_interrupt,
  output logic wakeup_input
);
  // Pins idle low between requests
  initial begin
    {system_break, ext_interrupt, wakeup_input} = 3'h0;
  end
  // One-cycle request, launched just after an edge so sampling is clean
  task automatic fire(input logic [2:0] m);
    {system_break, ext_interrupt, wakeup_input} = m;
    @(posedge ref_clk);
    #1;
    {system_break, ext_interrupt, wakeup_input} = 3'h0;
  endtask : fire
endmodule : irq_source

// ===== testbench/status_props.sv
`timescale 1ns/100ps
// ==========================================
// Port-level checker for the status unit
module status_props
  import cpu_state_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cr_we,
  input wire logic [2:0] cr_sel,
  input wire logic [31:0] cr_rdata,
  input wire logic cond_we,
  input wire logic cond_in,
  input wire logic return_from_event_instr,
  input wire logic [31:0] pc,
  input wire logic write_acc_low_instr,
  input wire logic [31:0] acc_wdata,
  input wire logic [1:0] acc_rsel,
  input wire logic [31:0] acc_rdata,
  input wire logic mem_valid,
  input wire mem_op_t mem_op,
  input wire logic [31:0] mem_addr,
  input wire addr_info_t addr_info,
  input wire logic [3:0] trap_operand,
  input wire logic wakeup_input,
  input wire logic event_taken,
  input wire event_t event_kind,
  input wire logic alignment_exception,
  input wire logic [1:0] power_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  a_cond_copy: assert property (cond_we && !cr_we && cr_sel == CR_CBR |=>
    cr_rdata == {31'h0, $past(cond_in)}) else $error("cond copy mismatch");
  a_bpc_lsb: assert property (cr_sel == CR_BPC |=> !cr_rdata[0])
    else $error("backup pc lsb set");
  a_ret_word: assert property (return_from_event_instr |=> pc[1:0] == 2'h0)
    else $error("return not word aligned");
  a_acc_low: assert property (write_acc_low_instr && acc_rsel == 2'h1 |=>
    acc_rdata == $past(acc_wdata)) else $error("acc low readback");
  a_pc_even: assert property (!pc[0]) else $error("pc lsb set");
  a_misalign_flag: assert property (mem_valid && ((mem_op inside {MEM_LH, MEM_LUH, MEM_SH}
    && mem_addr[0]) || (mem_op == MEM_LW && mem_addr[1:0] != 2'h0)) |=> alignment_exception)
    else $error("misaligned access missed");
  a_byte_any: assert property (mem_valid && mem_op inside {MEM_LB, MEM_LUB, MEM_SB}
    |=> !alignment_exception) else $error("byte access flagged");
  a_user_space: assert property (mem_valid && !mem_addr[31] |=> !addr_info.space_id)
    else $error("user space id");
  a_io_space: assert property (mem_valid && mem_addr[31] |=>
    addr_info.space_id && !addr_info.cacheable) else $error("io space id or cache");
  a_reset_vector: assert property (disable iff (1'b0) rst |=> pc == VEC_RESET)
    else $error("reset vector");
  a_wake_refused: assert property (wakeup_input && power_state == 2'h0 |=>
    !(event_taken && event_kind == EV_WI)) else $error("wakeup taken in run");
  a_sbi_vector: assert property (event_taken && event_kind == EV_SBI |-> pc == VEC_SBI)
    else $error("break vector");
  a_trap_vector: assert property (event_taken && event_kind == EV_TRAP |->
    pc == VEC_TRAP + {$past(trap_operand), 2'h0}) else $error("trap vector");
  // Main scenarios reached
  c_ei: cover property (event_taken && event_kind == EV_EI);
  c_wi: cover property (event_taken && event_kind == EV_WI);
  c_ae: cover property (alignment_exception);
endmodule : status_props
bind cpu_status_unit status_props u_props (.*);

// ===== testbench/tb_cpu_status_unit.sv
`timescale 1ns/100ps
module tb_cpu_status_unit
  import cpu_state_pkg::*;
;
  // ==========================================
  // Signals named as the unit's ports, plus check counters
  logic ref_clk, rst, cr_we, r15_we, cond_we, cond_in, pc_load, retire, save_next;
  logic return_from_event_instr, write_acc_high_instr, write_acc_low_instr, mem_valid;
  logic reserved_opcode, trap_instr, sleep_req, standby_req, slave_mode;
  logic system_break, ext_interrupt, wakeup_input, event_taken, alignment_exception;
  logic [2:0] cr_sel;
  logic [1:0] acc_rsel, power_state;
  logic [3:0] trap_operand;
  logic [31:0] cr_wdata, cr_rdata, r15_wdata, r15_rdata, pc_target, next_pc, pc;
  logic [31:0] acc_wdata, acc_rdata, mem_addr, mem_rdata, store_src, load_result;
  mem_op_t mem_op;
  store_t store_out;
  addr_info_t addr_info;
  event_t event_kind;
  int bad_count, tests_run;
  // Expected load results for ops 1..5 on a 0x85 byte pattern
  logic [31:0] lx [5] = '{32'hFFFF_FF85, 32'h0000_0085, 32'hFFFF_8585, 32'h0000_8585,
    32'h8585_8585};
  logic [31:0] ax [4] = '{32'h1234_5678, 32'h9ABC_DEF0, 32'h5678_9ABC, 32'h0000_0000};
  cpu_status_unit dut (.*);
  irq_source src (.*);
  // ==========================================
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
  // ==========================================
  // Tasks; inputs always move 1 ns after an edge
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[FAIL] %s exp %h got %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic cr_wr(input logic [2:0] s, input logic [31:0] d);
    {cr_we, cr_sel, cr_wdata} = {1'b1, s, d};
    tick;
    cr_we = 1'b0;
  endtask : cr_wr
  task automatic cr_rd(input logic [2:0] s, input logic [31:0] e);
    cr_sel = s;
    tick;
    chk("cr_rdata", e, cr_rdata);
  endtask : cr_rd
  task automatic ev_chk(input event_t k, input logic [31:0] v);
    chk("event", {28'h0, 1'b1, k}, {28'h0, event_taken, event_kind});
    chk("pc", v, pc);
  endtask : ev_chk
  task automatic al(input mem_op_t op, input logic [31:0] a, input logic e);
    {mem_op, mem_addr} = {op, a};
    tick;
    chk("align", {31'h0, e}, {31'h0, alignment_exception});
  endtask : al
  task automatic am(input logic [31:0] a, input logic s, input area_t r, input logic u);
    mem_addr = a;
    tick;
    chk("addr_info", {27'h0, s, r, u}, {27'h0, addr_info.space_id, addr_info.area,
      addr_info.usable});
    if (s) chk("cacheable", 32'h0, {31'h0, addr_info.cacheable});
  endtask : am
  task automatic pwr(input logic [1:0] e);
    tick;
    chk("power_state", {30'h0, e}, {30'h0, power_state});
  endtask : pwr
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // Main sequence
  initial begin
    {cr_we, r15_we, cond_we, cond_in, pc_load, retire, save_next, mem_valid} = 8'h00;
    {return_from_event_instr, write_acc_high_instr, write_acc_low_instr} = 3'h0;
    {reserved_opcode, trap_instr, sleep_req, standby_req, slave_mode, rst} = 6'h01;
    {cr_sel, acc_rsel, trap_operand, mem_op} = '0;
    {cr_wdata, r15_wdata, pc_target, next_pc, acc_wdata, mem_addr} = '0;
    {mem_rdata, store_src} = '0;
    repeat (20) tick;
    rst = 1'b0;
    chk("pc", VEC_RESET, pc);
    cr_wr(CR_PSW, 32'hFFFF_FFFF);
    cr_rd(CR_PSW, PSW_MASK);
    cr_wr(CR_PSW, 32'h0000_0000);
    {cond_we, cond_in, cr_sel} = {2'h3, CR_CBR};
    tick;
    cond_we = 1'b0;
    cr_wr(CR_CBR, 32'h0000_0000);
    cr_rd(CR_CBR, 32'h0000_0001);
    // Stack alias follows the stack mode bit
    {r15_we, r15_wdata} = {1'b1, 32'h0000_1110};
    tick;
    r15_we = 1'b0;
    cr_rd(CR_SPI, 32'h0000_1110);
    cr_wr(CR_PSW, 32'h0000_0081);
    cr_wr(CR_SPU, 32'h0000_2220);
    cr_rd(CR_SPU, 32'h0000_2220);
    chk("r15_rdata", 32'h0000_2220, r15_rdata);
    // Accumulator halves and three read views
    {write_acc_high_instr, acc_wdata} = {1'b1, ax[0]};
    tick;
    {write_acc_high_instr, write_acc_low_instr, acc_rsel, acc_wdata} = {2'h1, 2'h1, ax[1]};
    tick;
    write_acc_low_instr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc_rsel = i[1:0];
      tick;
      chk("acc_rdata", ax[i], acc_rdata);
    end
    // Load extension and store widths
    {mem_valid, mem_addr, mem_rdata, store_src} = {1'b1, 32'h0, 32'h8585_8585, 32'h1122_3344};
    for (int i = 1; i < 6; i++) begin
      mem_op = mem_op_t'(i);
      tick;
      chk("load_result", lx[i-1], load_result);
    end
    mem_op = MEM_SB;
    tick;
    chk("store_sb", 32'h11, {27'h0, store_out.we, store_out.byte_en});
    chk("wdata_sb", 32'h0000_0044, store_out.wdata);
    mem_op = MEM_SH;
    tick;
    chk("store_sh", 32'h13, {27'h0, store_out.we, store_out.byte_en});
    chk("wdata_sh", 32'h0000_3344, store_out.wdata);
    al(MEM_LH, 32'h1, 1'b1);
    al(MEM_LW, 32'h2, 1'b1);
    al(MEM_SH, 32'h3, 1'b1);
    al(MEM_LB, 32'h3, 1'b0);
    al(MEM_LUH, 32'h2, 1'b0);
    al(MEM_LW, 32'h4, 1'b0);
    mem_op = MEM_LB;
    am(32'h0000_0000, 1'b0, AREA_DRAM, 1'b1);
    am(DRAM_LIMIT, 1'b0, AREA_DRAM, 1'b1);
    am(EXT_BASE, 1'b0, AREA_EXT, 1'b1);
    am(VEC_RESET, 1'b0, AREA_EXT, 1'b1);
    am(32'h0100_0000, 1'b0, AREA_UNUSED, 1'b0);
    am(IO_SPACE_BASE, 1'b1, AREA_IO_UNUSED, 1'b0);
    am(UIO_BASE, 1'b1, AREA_UIO, 1'b1);
    am(UIO_LIMIT, 1'b1, AREA_UIO, 1'b1);
    am(SYS_BASE, 1'b1, AREA_SYS, 1'b0);
    am(INTIO_BASE, 1'b1, AREA_INTIO, 1'b1);
    mem_valid = 1'b0;
    // Masked interrupt, then a taken one saving status and next pc
    cr_wr(CR_PSW, 32'h0000_0000);
    src.fire(3'h2);
    chk("event_taken", 32'h0, {31'h0, event_taken});
    {pc_load, pc_target} = {1'b1, 32'h0000_1237};
    tick;
    pc_load = 1'b0;
    chk("pc", 32'h0000_1236, pc);
    {retire, next_pc} = {1'b1, 32'h0000_3003};
    tick;
    retire = 1'b0;
    chk("pc", 32'h0000_3002, pc);
    cr_wr(CR_PSW, 32'h0000_00C1);
    {save_next, next_pc} = {1'b1, 32'h0000_2006};
    src.fire(3'h2);
    ev_chk(EV_EI, VEC_EI);
    save_next = 1'b0;
    cr_sel = CR_PSW;
    tick;
    chk("psw", 32'h0000_C100, cr_rdata & 32'h0000_FFC0);
    cr_rd(CR_BPC, 32'h0000_2006);
    return_from_event_instr = 1'b1;
    tick;
    return_from_event_instr = 1'b0;
    chk("pc", 32'h0000_2004, pc);
    cr_wr(CR_BPC, 32'hFFFF_FFFF);
    cr_rd(CR_BPC, 32'hFFFF_FFFE);
    // Break ignores the enable bit; reserved opcode; all trap vectors
    cr_wr(CR_PSW, 32'h0000_0000);
    src.fire(3'h4);
    ev_chk(EV_SBI, VEC_SBI);
    reserved_opcode = 1'b1;
    tick;
    reserved_opcode = 1'b0;
    ev_chk(EV_RIE, VEC_RIE);
    trap_instr = 1'b1;
    for (int n = 0; n < 16; n++) begin
      trap_operand = n[3:0];
      tick;
      ev_chk(EV_TRAP, VEC_TRAP + 32'(n * 4));
    end
    // Simultaneous sources resolve by fixed priority
    reserved_opcode = 1'b1;
    cr_wr(CR_PSW, 32'h0000_0040);
    src.fire(3'h6);
    {trap_instr, reserved_opcode} = 2'h0;
    ev_chk(EV_SBI, VEC_SBI);
    // Wakeup only from standby; sleep ended by break and interrupt
    src.fire(3'h1);
    chk("event_taken", 32'h0, {31'h0, event_taken});
    standby_req = 1'b1;
    tick;
    standby_req = 1'b0;
    pwr(2'h3);
    src.fire(3'h1);
    ev_chk(EV_WI, VEC_WI);
    pwr(2'h0);
    sleep_req = 1'b1;
    pwr(2'h1);
    sleep_req = 1'b0;
    src.fire(3'h4);
    pwr(2'h0);
    cr_wr(CR_PSW, 32'h0000_0040);
    sleep_req = 1'b1;
    pwr(2'h1);
    sleep_req = 1'b0;
    src.fire(3'h2);
    pwr(2'h0);
    // Second reset into slave wait, started by a break
    {rst, slave_mode} = 2'h3;
    tick;
    rst = 1'b0;
    tick;
    pwr(2'h2);
    slave_mode = 1'b0;
    src.fire(3'h4);
    pwr(2'h0);
    print_verdict();
  end
endmodule : tb_cpu_status_unit
